//--- src/sbmc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - The mux address is taken from the low five data lines, and only while read strobe is high.
// - A conversion starts only through chip select and write strobe, both low.
// - The done flag stays low until the result is read or a selected write strobe falls.
// - A falling write strobe with chip select low drives the done flag high and readies a new conversion.
// - A rising write strobe with read high latches the address, applies it and starts conversion.
// - Read held low through the whole write pulse keeps the old mux setting and drives the old result.
// - Each conversion ends within the maximum time, loads the output latch and pulls done low.
// - Chip select and read both low set done high and put the stored result on the data lines.
// - The result is positive minus negative input, and all zeros when positive is below negative.
// - Differential mode picks pair one-two or three-four by bit 1, bit 0 swaps polarity.
// - Single-ended mode picks one of four inputs as positive against analog ground.
// - Pseudo-differential mode picks input one to three as positive against input four.
// - The result is an eight-bit code of 256 steps, one step being the reference over 256.
module sbmc_ctrl #(
    parameter int CONV_CYCLES = sbmc_pkg::CONV_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       cs_n,
    input  wire logic       wr_n,
    input  wire logic       rd_n,
    input  wire logic [7:0] shared_data_lines_in,
    output logic [7:0]      shared_data_lines_out,
    output logic            shared_data_lines_oe,
    output logic            conversion_done_n,
    output logic [7:0]      sample_pos_sel,
    output logic [7:0]      sample_neg_sel,
    output logic            conv_sample,
    output logic [4:0]      mux_address_bits,
    input  wire logic [7:0] analog_pos_code,
    input  wire logic [7:0] analog_neg_code,
    output logic [3:0]      mux_mode
);
    // sample_*_sel bit k selects analog input k+1; bit 4 is analog ground

    logic       cs_s, wr_s, rd_s;
    logic [7:0] db_s;
    logic       wr_d_r;
    logic       rd_low_r;
    logic       cs_low_r;
    logic [4:0] addr_r;
    logic [7:0] result_r;
    // Counter is sized from the parameter so a longer conversion still fits
    logic [$clog2(CONV_CYCLES+1)-1:0] cnt_r;
    logic       wr_fall, wr_rise;
    sbmc_pkg::sbmc_state_e state_r;

    // Pins come from the host's domain
    sbmc_sync #(.W(3), .RST_V(1'b1)) u_ctl_sync (
        .clk (clk),
        .rst (rst),
        .d   ({cs_n, wr_n, rd_n}),
        .q   ({cs_s, wr_s, rd_s})
    );
    sbmc_sync #(.W(8), .RST_V(1'b0)) u_db_sync (
        .clk (clk),
        .rst (rst),
        .d   (shared_data_lines_in),
        .q   (db_s)
    );

    // Write falls only count while chip selected; a rise counts after a selected fall
    assign wr_fall = wr_d_r && !wr_s && !cs_s;
    assign wr_rise = !wr_d_r && wr_s && cs_low_r;

    // Decode mux address into mode; used for output and steering
    function automatic sbmc_pkg::sbmc_mode_e mode_of(input logic [4:0] a);
        if (!a[sbmc_pkg::MA_SE])
            return sbmc_pkg::SBMC_DIFF;
        else if (!a[sbmc_pkg::MA_PD])
            return sbmc_pkg::SBMC_SINGLE;
        else if (a[1:0] != 2'h3)
            return sbmc_pkg::SBMC_PSEUDO;
        else
            return sbmc_pkg::SBMC_UNDEF;
    endfunction

    // Write strobe edge and read-low tracking over the write pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_d_r   <= 1'b1;
            rd_low_r <= 1'b0;
            cs_low_r <= 1'b0;
        end else begin
            wr_d_r <= wr_s;
            if (wr_fall) begin
                rd_low_r <= !rd_s;
                cs_low_r <= 1'b1;
            end else if (!wr_s) begin
                rd_low_r <= rd_low_r && !rd_s;
            end else if (!wr_rise) begin
                cs_low_r <= 1'b0;
            end
        end
    end

    // Address latch; a write with read held low keeps the old setting
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_r <= sbmc_pkg::MUXADR_RST;
        end else if (wr_rise && rd_s && !rd_low_r) begin
            addr_r <= db_s[4:0];
        end
    end

    // Conversion sequencer; counter limit fixes the worst-case time
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= sbmc_pkg::SBMC_IDLE;
            cnt_r   <= '0;
        end else begin
            unique case (state_r)
                sbmc_pkg::SBMC_IDLE: begin
                    if (wr_fall) begin
                        state_r <= sbmc_pkg::SBMC_ARM;
                    end
                end
                sbmc_pkg::SBMC_ARM: begin
                    if (wr_rise) begin
                        state_r <= sbmc_pkg::SBMC_CONV;
                        cnt_r   <= '0;
                    end
                end
                sbmc_pkg::SBMC_CONV: begin
                    if (wr_fall) begin
                        state_r <= sbmc_pkg::SBMC_ARM;
                    end else if (cnt_r == $bits(cnt_r)'(CONV_CYCLES - 1)) begin
                        state_r <= sbmc_pkg::SBMC_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // Last count of an uncut conversion; a new write fall wins over the end
    logic conv_end;
    assign conv_end = state_r == sbmc_pkg::SBMC_CONV && !wr_fall
                      && cnt_r == $bits(cnt_r)'(CONV_CYCLES - 1);

    // Result: difference clamps to zero; 8-bit code, step = ref/256
    always_ff @(posedge clk) begin
        if (rst) begin
            result_r <= sbmc_pkg::RESULT_RST;
        end else if (conv_end) begin
            if (analog_pos_code > analog_neg_code)
                result_r <= analog_pos_code - analog_neg_code;
            else
                result_r <= 8'h00;
        end
    end

    // Done flag: set wins when an end and a read coincide
    always_ff @(posedge clk) begin
        if (rst) begin
            conversion_done_n <= 1'b1;
        end else if (conv_end) begin
            conversion_done_n <= 1'b0;
        end else if (wr_fall || (!cs_s && !rd_s)) begin
            conversion_done_n <= 1'b1;
        end
    end // Stays low until read or new write

    // Data bus drive during a selected read
    always_ff @(posedge clk) begin
        if (rst) begin
            shared_data_lines_oe  <= 1'b0;
            shared_data_lines_out <= sbmc_pkg::RESULT_RST;
        end else begin
            shared_data_lines_oe  <= !cs_s && !rd_s;
            shared_data_lines_out <= conv_end ? shared_data_lines_out : result_r;
        end
    end

    // Input steering from the latched address
    always_ff @(posedge clk) begin
        if (rst) begin
            sample_pos_sel   <= 8'h00;
            sample_neg_sel   <= 8'h00;
            conv_sample      <= 1'b0;
            mux_address_bits <= sbmc_pkg::MUXADR_RST;
            mux_mode         <= 4'h0;
        end else begin
            conv_sample      <= state_r == sbmc_pkg::SBMC_CONV;
            mux_address_bits <= addr_r;
            mux_mode         <= mode_of(addr_r);
            sample_pos_sel   <= 8'h00;
            sample_neg_sel   <= 8'h00;
            unique case (mode_of(addr_r))
                sbmc_pkg::SBMC_DIFF: begin
                    sample_pos_sel[{addr_r[1], addr_r[0]}] <= 1'b1;
                    sample_neg_sel[{addr_r[1], ~addr_r[0]}] <= 1'b1;
                end
                sbmc_pkg::SBMC_SINGLE: begin
                    sample_pos_sel[addr_r[1:0]] <= 1'b1;
                    sample_neg_sel[4]           <= 1'b1;
                end
                sbmc_pkg::SBMC_PSEUDO: begin
                    sample_pos_sel[addr_r[1:0]] <= 1'b1;
                    sample_neg_sel[3]           <= 1'b1;
                end
                sbmc_pkg::SBMC_UNDEF: begin
                    sample_pos_sel <= 8'h00; // Host must avoid
                end
            endcase
        end
    end

    // Helper: cycles spent converting
    logic [15:0] conv_age_r;
    always_ff @(posedge clk) begin
        if (rst || state_r != sbmc_pkg::SBMC_CONV)
            conv_age_r <= 16'h0000;
        else
            conv_age_r <= conv_age_r + 16'h0001;
    end

    // Write fall must raise the flag on the following cycle
    sequence s_wr_fall;
        wr_fall;
    endsequence
    sequence s_done_high;
        ##1 conversion_done_n;
    endsequence

    a_fall_clears_done: assert property (@(posedge clk) disable iff (rst)
        s_wr_fall |-> s_done_high) else $error("done not set high after write fall");
    a_read_clears_done: assert property (@(posedge clk) disable iff (rst)
        (!cs_s && !rd_s && !conv_end) |=> conversion_done_n) else $error("read left done low");
    a_read_drives_bus: assert property (@(posedge clk) disable iff (rst)
        (!cs_s && !rd_s) |=> shared_data_lines_oe) else $error("bus not driven on read");
    a_conv_time_max: assert property (@(posedge clk) disable iff (rst)
        conv_age_r <= 16'(CONV_CYCLES)) else $error("conversion overran");
    a_end_sets_done: assert property (@(posedge clk) disable iff (rst)
        conv_end |=> !conversion_done_n) else $error("done not low at end");
    a_done_held_low: assert property (@(posedge clk) disable iff (rst)
        (!conversion_done_n && !wr_fall && (cs_s || rd_s)) |=> !conversion_done_n)
        else $error("done rose unread");
    a_rd_low_keeps: assert property (@(posedge clk) disable iff (rst)
        (wr_rise && rd_low_r) |=> $stable(addr_r)) else $error("address changed on read");
    a_addr_latch: assert property (@(posedge clk) disable iff (rst)
        (wr_rise && rd_s && !rd_low_r) |=> addr_r == $past(db_s[4:0]))
        else $error("address not latched");
    a_start_conv: assert property (@(posedge clk) disable iff (rst)
        (wr_rise && state_r == sbmc_pkg::SBMC_ARM) |=> state_r == sbmc_pkg::SBMC_CONV)
        else $error("conversion not started");
    a_clamp_zero: assert property (@(posedge clk) disable iff (rst)
        (conv_end && analog_pos_code <= analog_neg_code) |=> result_r == 8'h00)
        else $error("negative difference not zero");
    a_no_start_w_o_cs: assert property (@(posedge clk) disable iff (rst)
        (wr_d_r && !wr_s && cs_s && state_r != sbmc_pkg::SBMC_CONV)
        |=> $stable(state_r) && $stable(conversion_done_n))
        else $error("unselected write acted");

    // Sequencing, counter range, the stored result and bus release
    a_fall_rearms: assert property (@(posedge clk) disable iff (rst)
        wr_fall |=> state_r == sbmc_pkg::SBMC_ARM) else $error("write fall did not arm");
    a_start_clears_cnt: assert property (@(posedge clk) disable iff (rst)
        (wr_rise && state_r == sbmc_pkg::SBMC_ARM) |=> cnt_r == '0)
        else $error("counter not cleared at start");
    a_sample_during: assert property (@(posedge clk) disable iff (rst)
        (state_r == sbmc_pkg::SBMC_CONV) |=> conv_sample) else $error("sample strobe missing");
    a_cnt_in_range: assert property (@(posedge clk) disable iff (rst)
        (state_r == sbmc_pkg::SBMC_CONV) |-> cnt_r < $bits(cnt_r)'(CONV_CYCLES))
        else $error("conversion counter out of range");
    a_result_held: assert property (@(posedge clk) disable iff (rst)
        !conv_end |=> $stable(result_r)) else $error("result changed outside an end");
    a_result_diff: assert property (@(posedge clk) disable iff (rst)
        (conv_end && analog_pos_code > analog_neg_code)
        |=> result_r == $past(analog_pos_code) - $past(analog_neg_code))
        else $error("result is not the difference");
    a_bus_released: assert property (@(posedge clk) disable iff (rst)
        (cs_s || rd_s) |=> !shared_data_lines_oe) else $error("bus driven without read");

    // Steering is checked against the address held one cycle before
    sequence s_diff_addr;
        !addr_r[sbmc_pkg::MA_SE];
    endsequence
    sequence s_pair_steered;
        (sample_pos_sel | sample_neg_sel)
            == ($past(addr_r[sbmc_pkg::MA_PAIR]) ? 8'h0C : 8'h03);
    endsequence

    a_diff_pair: assert property (@(posedge clk) disable iff (rst)
        s_diff_addr |=> s_pair_steered) else $error("wrong differential pair");
    a_diff_polarity: assert property (@(posedge clk) disable iff (rst)
        s_diff_addr |=> sample_pos_sel[$past(addr_r[1:0])] && !sample_neg_sel[$past(addr_r[1:0])])
        else $error("wrong differential polarity");
    a_single_ground: assert property (@(posedge clk) disable iff (rst)
        (addr_r[sbmc_pkg::MA_SE] && !addr_r[sbmc_pkg::MA_PD])
        |=> sample_neg_sel == 8'h10 && sample_pos_sel[$past(addr_r[1:0])])
        else $error("single-ended steering wrong");
    a_pseudo_ref: assert property (@(posedge clk) disable iff (rst)
        (addr_r[sbmc_pkg::MA_SE] && addr_r[sbmc_pkg::MA_PD] && addr_r[1:0] != 2'h3)
        |=> sample_neg_sel == 8'h08 && sample_pos_sel[$past(addr_r[1:0])])
        else $error("pseudo-differential steering wrong");
    a_undef_no_sel: assert property (@(posedge clk) disable iff (rst)
        (addr_r[3:0] == 4'hF) |=> sample_pos_sel == 8'h00 && sample_neg_sel == 8'h00)
        else $error("undefined address selected an input");
endmodule // sbmc_ctrl
`default_nettype wire

//--- src/sbmc_pkg.sv
package sbmc_pkg;
    // Data and address widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int CODES  = 256;

    // Mux address field positions
    localparam int MA_SWAP = 0;
    localparam int MA_PAIR = 1;
    localparam int MA_SE   = 2;
    localparam int MA_PD   = 3;

    // Timing, clock period in ps, times in ns
    localparam int CLK_PS      = 5000;
    localparam int T_CONV_NS   = 40000;
    localparam int CONV_CYC    = (T_CONV_NS * 1000) / CLK_PS;
    localparam int T_RD_WAIT_NS = 600;

    // Reset values
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [4:0] MUXADR_RST = 5'h00;

    // Mux modes
    typedef enum logic [3:0] {
        SBMC_DIFF   = 4'h1,
        SBMC_SINGLE = 4'h2,
        SBMC_PSEUDO = 4'h4,
        SBMC_UNDEF  = 4'h8
    } sbmc_mode_e;

    // Converter states
    typedef enum logic [2:0] {
        SBMC_IDLE = 3'h1,
        SBMC_ARM  = 3'h2,
        SBMC_CONV = 3'h4
    } sbmc_state_e;
endpackage

//--- src/sbmc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-flop synchroniser; output changes only once stages two and three agree
module sbmc_sync #(
    parameter int   W     = 1,
    parameter logic RST_V = 1'b1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // Stage one feeds only stage two
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= {W{RST_V}};
            s2_r <= {W{RST_V}};
            s3_r <= {W{RST_V}};
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Per-bit filter so a one-cycle glitch on a line never reaches the logic
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    q[i] <= RST_V;
                end else if (s2_r[i] == s3_r[i]) begin
                    q[i] <= s3_r[i];
                end
            end
        end
    endgenerate
endmodule // sbmc_sync
`default_nettype wire

//--- verif/sbmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host bus model; strobes stay put for many cycles because the device sees them late
module sbmc_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] bus,
    output logic            cs_n,
    output logic            wr_n,
    output logic            rd_n,
    output logic [7:0]      host_d,
    output logic            host_oe
);
    initial begin
        cs_n = 1'b1; wr_n = 1'b1; rd_n = 1'b1; host_d = 8'h00; host_oe = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Write pulse; rd_low holds read low all through it, seen is the bus at the rising edge
    task automatic write(input logic [4:0] adr, input logic use_cs, input logic rd_low,
                         output logic [7:0] seen);
        step(6); // Idle gap long enough for the filters to see the strobes high
        cs_n = ~use_cs;
        rd_n = ~rd_low;
        wr_n = 1'b0;
        host_d = {3'h0, adr};
        host_oe = ~rd_low;
        step(10);
        seen = bus;
        wr_n = 1'b1;
        step(3);
        cs_n = 1'b1; rd_n = 1'b1; host_oe = 1'b0;
        host_d = ~host_d; // Released lines must not keep the last value
    endtask
    // Read after the settling wait that the done flag needs
    task automatic read(output logic [7:0] v);
        step(120);
        cs_n = 1'b0; rd_n = 1'b0;
        step(10);
        v = bus;
        cs_n = 1'b1; rd_n = 1'b1;
    endtask
endmodule // sbmc_host_model
`default_nettype wire

//--- verif/test_sbmc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_sbmc_ctrl;
    logic       clk = 1'b0, rst = 1'b1;
    logic       cs_n, wr_n, rd_n, oe, done_n, smp, hoe;
    logic [7:0] dout, hd, bus, psel, nsel, pos_code, neg_code, v, vin[4];
    logic [7:0] last_bus = 8'h00;
    logic [4:0] madr, a;
    logic [3:0] mode;
    int         num_errors = 0, n_checks = 0;
    always #2.5 clk = ~clk;
    // Shared lines: device, then host, else a pattern that flips every cycle
    assign bus = oe ? dout : (hoe ? hd : ~last_bus);
    always @(posedge clk) last_bus <= bus;
    // Analog stand-in: the selected inputs' levels, ground reads as zero
    always_comb begin
        pos_code = 8'h00; neg_code = 8'h00;
        for (int k = 0; k < 4; k++) begin
            if (psel[k]) pos_code = vin[k];
            if (nsel[k]) neg_code = vin[k];
        end
    end
    sbmc_host_model host (.clk(clk), .bus(bus), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
                          .host_d(hd), .host_oe(hoe));
    sbmc_ctrl #(.CONV_CYCLES(20)) DUT (
        .clk(clk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .shared_data_lines_in(bus), .shared_data_lines_out(dout),
        .shared_data_lines_oe(oe), .conversion_done_n(done_n),
        .sample_pos_sel(psel), .sample_neg_sel(nsel), .conv_sample(smp),
        .mux_address_bits(madr), .analog_pos_code(pos_code),
        .analog_neg_code(neg_code), .mux_mode(mode));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
            num_errors++;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Bounded wait for the done flag to fall
    task automatic wait_done();
        int i;
        for (i = 0; i < 200 && done_n !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 200) begin
            $display("ERROR t=%0t done flag never fell", $time);
            num_errors++;
            give_verdict();
        end
    endtask
    // Expected selections and result for an address
    function automatic void expect_of(input logic [4:0] ad, output logic [7:0] ps,
                                      output logic [7:0] ns, output logic [7:0] r,
                                      output logic [7:0] md);
        int p, n;
        logic [7:0] nv;
        if (!ad[2]) begin
            p = 2 * ad[1] + ad[0]; n = 2 * ad[1] + !ad[0]; md = 8'h01;
        end else begin
            p = ad[1:0]; n = ad[3] ? 3 : 4; md = ad[3] ? 8'h04 : 8'h02;
        end
        ps = 8'h01 << p;
        ns = 8'h01 << n;
        nv = (n == 4) ? 8'h00 : vin[n];
        r = (vin[p] > nv) ? vin[p] - nv : 8'h00;
    endfunction
    // One full conversion and read at an address
    task automatic convert(input logic [4:0] ad);
        logic [7:0] ps, ns, r, md, sn;
        expect_of(ad, ps, ns, r, md);
        host.write(ad, 1'b1, 1'b0, sn);
        check({7'h00, done_n}, 8'h01);
        host.step(5);
        check({7'h00, smp}, 8'h01);
        wait_done();
        check({3'h0, madr}, {3'h0, ad});
        check({4'h0, mode}, md);
        check(psel, ps);
        check(nsel, ns);
        host.step(1);
        check({7'h00, smp}, 8'h00);
        host.read(v);
        check(v, r);
        check({7'h00, oe}, 8'h01);
        check({7'h00, done_n}, 8'h01);
    endtask
    initial begin
        for (int k = 0; k < 4; k++) vin[k] = 8'h00;
        void'($urandom(54712));
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        host.step(4);
        check({7'h00, done_n}, 8'h01);
        check({7'h00, oe}, 8'h00);
        // Every listed address, the all-high one left out, random levels
        for (int i = 0; i < 15; i++) begin
            for (int k = 0; k < 4; k++) vin[k] = 8'($urandom_range(255));
            if (i == 3) vin[3] = vin[2]; // Equal inputs give zero
            a = {1'($urandom_range(1)), 4'(i)};
            convert(a);
        end
        $display("test addresses done");
        // Negative difference and full scale corners
        vin[0] = 8'h10; vin[1] = 8'hF0; vin[2] = 8'hFF; vin[3] = 8'h00;
        convert(5'h00);
        convert(5'h06);
        $display("test corners done");
        // Unread result keeps the flag low; a write without chip select is ignored
        host.write(5'h0C, 1'b1, 1'b0, v);
        wait_done();
        host.step(30);
        check({7'h00, done_n}, 8'h00);
        host.write(5'h05, 1'b0, 1'b0, v);
        check({7'h00, done_n}, 8'h00);
        check({3'h0, madr}, 8'h0C);
        host.read(v);
        check(v, vin[0] > vin[3] ? vin[0] - vin[3] : 8'h00);
        // A selected write over an unread result raises the flag again
        host.write(5'h0C, 1'b1, 1'b0, v);
        wait_done();
        convert(5'h0C);
        $display("test unread done");
        // Read held low through the write keeps the old setting and shows the old result
        convert(5'h06);
        host.write(5'h01, 1'b1, 1'b1, v);
        check(v, 8'hFF);
        wait_done();
        check({3'h0, madr}, 8'h06);
        host.read(v);
        check(v, 8'hFF);
        $display("test keep done");
        give_verdict();
    end
endmodule // test_sbmc_ctrl
`default_nettype wire
